// >>> hw/msl_top.sv
`timescale 1ns/1ps

// ********************************************************************
// Mode select, security and low-power controller
// ********************************************************************

// Summary of operation
// - Mode pins latch into the mode register at reset release.
// - Flash visibility strap latches into the flash-enable bit at release.
// - Flash-enable one maps flash; zero removes it from the map.
// - Mode register reports mode; writes allow limited mode changes only.
// - Pattern 000: special single chip, debug active, flash enabled.
// - Other modes: debug permitted, active only after a serial command.
// - Pattern 001: emulation narrow, flash enable is inverted strap.
// - Pattern 010: special test wide, flash enable forced zero.
// - Pattern 011: emulation wide, flash enable is inverted strap.
// - Pattern 100: normal single chip, flash enable forced one.
// - Pattern 101: normal narrow, flash enable equals strap.
// - Pattern 111: normal wide, flash enable equals strap.
// - Oscillator pin: one selects Colpitts, zero Pierce or external.
// - Secured state comes from nonvolatile flash security bits.
// - Secured normal single chip: everything normal except debug blocked.
// - Secured reset into expanded mode: flash disabled, debug blocked.
// - Erase verify in special single chip; early reset keeps it secured.
// - Full stop halts all clocks and oscillator; reset or irq wakes.
// - Pseudo stop keeps oscillator, timer and watchdog; faster wake.
// - Wait halts processor, buses static, peripherals clocked.
module msl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire msl_pkg::msl_straps_t straps,
    input wire logic nv_secure,
    input wire logic flash_erased,
    input wire logic dbg_activate,
    input wire msl_pkg::msl_cpu_req_t cpu_req,
    output logic flash_mapped,
    output logic debug_active,
    output logic debug_blocked,
    output logic osc_colpitts,
    output logic osc_enable,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic lp_keep_en,
    output logic cpu_halt
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Flash enable from mode and strap at reset release
    function automatic logic flash_for_mode(msl_pkg::msl_mode_t m,
                                            logic strap);
        case (m)
            msl_pkg::MSL_SPECIAL_SINGLE: flash_for_mode = 1'b1;
            msl_pkg::MSL_EMUL_NARROW: flash_for_mode = ~strap;
            msl_pkg::MSL_SPECIAL_TEST: flash_for_mode = 1'b0;
            msl_pkg::MSL_EMUL_WIDE: flash_for_mode = ~strap;
            msl_pkg::MSL_NORMAL_SINGLE: flash_for_mode = 1'b1;
            msl_pkg::MSL_NORMAL_NARROW: flash_for_mode = strap;
            msl_pkg::MSL_PERIPHERAL: flash_for_mode = 1'b1;
            msl_pkg::MSL_NORMAL_WIDE: flash_for_mode = strap;
            default: flash_for_mode = 1'b0;
        endcase
    endfunction : flash_for_mode

    // Expanded bus modes, where secured flash must be hidden
    function automatic logic is_expanded(msl_pkg::msl_mode_t m);
        is_expanded = (m != msl_pkg::MSL_SPECIAL_SINGLE) &&
                      (m != msl_pkg::MSL_NORMAL_SINGLE) &&
                      (m != msl_pkg::MSL_PERIPHERAL);
    endfunction : is_expanded

    // Allowed run-time mode changes: special to any non-peripheral,
    // normal single chip only to a normal expanded mode
    function automatic logic mode_change_ok(msl_pkg::msl_mode_t from,
                                            msl_pkg::msl_mode_t to);
        logic special;
        special = (from == msl_pkg::MSL_SPECIAL_SINGLE) ||
                  (from == msl_pkg::MSL_SPECIAL_TEST);
        if (to == msl_pkg::MSL_PERIPHERAL) begin
            mode_change_ok = 1'b0;
        end else if (special) begin
            mode_change_ok = 1'b1;
        end else if (from == msl_pkg::MSL_NORMAL_SINGLE) begin
            mode_change_ok = (to == msl_pkg::MSL_NORMAL_NARROW) ||
                             (to == msl_pkg::MSL_NORMAL_WIDE);
        end else begin
            mode_change_ok = 1'b0;
        end
    endfunction : mode_change_ok

    // ****************************************************************
    // Pin synchronisers and strap capture
    // ****************************************************************
    msl_pkg::msl_straps_t straps_s;
    logic [2:0] misc_in;
    logic [2:0] misc_s;
    logic nv_secure_s;
    logic flash_erased_s;
    logic dbg_activate_s;

    assign misc_in = {nv_secure, flash_erased, dbg_activate};
    assign nv_secure_s = misc_s[2];
    assign flash_erased_s = misc_s[1];
    assign dbg_activate_s = misc_s[0];

    msl_sync #(.WIDTH($bits(msl_pkg::msl_straps_t))) u_strap_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(straps),
        .dout(straps_s)
    );

    msl_sync #(.WIDTH(3)) u_misc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(misc_in),
        .dout(misc_s)
    );

    // Sync delay: capture at the third edge after release, once
    logic [1:0] settle;
    logic captured;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 2'h0;
            captured <= 1'b0;
        end else if (!captured) begin
            settle <= settle + 2'h1;
            captured <= (settle == 2'h2);
        end
    end

    logic do_capture;
    assign do_capture = !captured && (settle == 2'h2);

    // ****************************************************************
    // Mode, flash and security state
    // ****************************************************************
    msl_pkg::msl_mode_t mode;
    logic flash_en;
    logic osc_sel;
    logic secured;
    logic dbg_act;
    logic pseudo_sel;
    logic wr_en;
    logic [31:0] wdata;
    msl_pkg::msl_mode_t wr_mode;

    assign wr_en = psel && penable && pwrite;
    assign wdata = pwdata;
    assign wr_mode = msl_pkg::msl_mode_t'(wdata[2:0]);

    // Mode latches at release, then only legal switches take effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= msl_pkg::MSL_SPECIAL_SINGLE;
        end else if (do_capture) begin
            mode <= msl_pkg::msl_mode_t'({straps_s.mode_select_hi,
                                          straps_s.mode_select_mid,
                                          straps_s.mode_select_lo});
        end else if (wr_en && paddr == msl_pkg::ADDR_MODE &&
                     mode_change_ok(mode, wr_mode)) begin
            mode <= wr_mode;
        end
    end

    // Secured flag sampled from nonvolatile bits at every reset,
    // so a reset before reprogramming leaves it secured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secured <= 1'b1;
        end else if (do_capture) begin
            secured <= nv_secure_s;
        end else if (!nv_secure_s && flash_erased_s) begin
            secured <= 1'b0;
        end
    end

    // Flash enable from strap and mode; secured expanded hides flash
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_en <= 1'b0;
        end else if (do_capture) begin
            flash_en <= flash_for_mode(
                msl_pkg::msl_mode_t'({straps_s.mode_select_hi,
                                      straps_s.mode_select_mid,
                                      straps_s.mode_select_lo}),
                straps_s.flash_visibility_strap);
        end else if (wr_en && paddr == msl_pkg::ADDR_MISC) begin
            flash_en <= wdata[msl_pkg::MISC_FLASH_EN_BIT];
        end
    end

    // Oscillator type is fixed from the strap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sel <= 1'b0;
        end else if (do_capture) begin
            osc_sel <= straps_s.oscillator_type_select;
        end
    end

    // Debug active at once in special single chip, else on command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_act <= 1'b0;
        end else if (do_capture) begin
            dbg_act <= ({straps_s.mode_select_hi, straps_s.mode_select_mid,
                         straps_s.mode_select_lo} ==
                        msl_pkg::MSL_SPECIAL_SINGLE);
        end else if (captured && dbg_activate_s) begin
            dbg_act <= 1'b1;
        end
    end

    // Stop flavour config bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pseudo_sel <= 1'b0;
        end else if (wr_en && paddr == msl_pkg::ADDR_LPCTL) begin
            pseudo_sel <= wdata[msl_pkg::LP_PSEUDO_BIT];
        end
    end

    // ****************************************************************
    // Low-power sequencing
    // ****************************************************************
    msl_pkg::msl_lp_t lp_state;

    msl_lowpower u_lp (
        .pclk(pclk),
        .presetn(presetn),
        .req(cpu_req),
        .pseudo_sel(pseudo_sel),
        .state(lp_state)
    );

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic blocked;
    // Secured part blocks debug in every mode it can be reset into,
    // except special single chip which runs the erase verify
    assign blocked = secured &&
                     (mode != msl_pkg::MSL_SPECIAL_SINGLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_mapped <= 1'b0;
            debug_active <= 1'b0;
            debug_blocked <= 1'b0;
            osc_colpitts <= 1'b0;
        end else begin
            flash_mapped <= flash_en &&
                            !(secured && is_expanded(mode));
            debug_active <= dbg_act && !blocked;
            debug_blocked <= blocked;
            osc_colpitts <= osc_sel;
        end
    end

    // Clock gating per low-power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_enable <= 1'b1;
            core_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            lp_keep_en <= 1'b1;
            cpu_halt <= 1'b0;
        end else begin
            osc_enable <= (lp_state != msl_pkg::MSL_LP_STOP);
            core_clk_en <= (lp_state == msl_pkg::MSL_LP_RUN) ||
                           (lp_state == msl_pkg::MSL_LP_WAIT);
            periph_clk_en <= (lp_state == msl_pkg::MSL_LP_RUN) ||
                             (lp_state == msl_pkg::MSL_LP_WAIT);
            lp_keep_en <= (lp_state != msl_pkg::MSL_LP_STOP);
            cpu_halt <= (lp_state != msl_pkg::MSL_LP_RUN);
        end
    end

    // ****************************************************************
    // APB slave, one wait-free cycle; unmapped reads and writes error
    // ****************************************************************
    logic [31:0] next_rdata;
    logic next_err;

    always_comb begin
        next_rdata = msl_pkg::RESET_DATA;
        next_err = 1'b0;
        case (paddr)
            msl_pkg::ADDR_MODE: next_rdata[2:0] = mode;
            msl_pkg::ADDR_MISC: begin
                next_rdata[msl_pkg::MISC_FLASH_EN_BIT] = flash_en;
                next_rdata[msl_pkg::MISC_OSC_BIT] = osc_sel;
            end
            msl_pkg::ADDR_SEC: begin
                next_rdata[msl_pkg::SEC_SECURED_BIT] = secured;
                next_rdata[msl_pkg::SEC_ERASED_BIT] = flash_erased_s;
            end
            msl_pkg::ADDR_LPCTL:
                next_rdata[msl_pkg::LP_PSEUDO_BIT] = pseudo_sel;
            msl_pkg::ADDR_STATUS: begin
                next_rdata[msl_pkg::ST_DBG_ACT_BIT] = dbg_act && !blocked;
                next_rdata[msl_pkg::ST_DBG_BLK_BIT] = blocked;
                next_rdata[msl_pkg::ST_LP_LSB +: 2] = lp_state;
            end
            default: next_err = 1'b1;
        endcase
    end

    // Ready is registered from the setup cycle, so it is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= msl_pkg::RESET_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (psel && !penable && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

endmodule : msl_top

// >>> hw/msl_pkg.sv
package msl_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_MISC = 12'h004;
    localparam logic [11:0] ADDR_SEC = 12'h008;
    localparam logic [11:0] ADDR_LPCTL = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MISC_FLASH_EN_BIT = 0;
    localparam int MISC_OSC_BIT = 1;
    localparam int SEC_SECURED_BIT = 0;
    localparam int SEC_ERASED_BIT = 1;
    localparam int LP_PSEUDO_BIT = 0;
    localparam int ST_DBG_ACT_BIT = 0;
    localparam int ST_DBG_BLK_BIT = 1;
    localparam int ST_LP_LSB = 2;

    // ****************************************************************
    // Operating modes, pin pattern hi,mid,lo
    // ****************************************************************
    typedef enum logic [2:0] {
        MSL_SPECIAL_SINGLE = 3'h0,
        MSL_EMUL_NARROW = 3'h1,
        MSL_SPECIAL_TEST = 3'h2,
        MSL_EMUL_WIDE = 3'h3,
        MSL_NORMAL_SINGLE = 3'h4,
        MSL_NORMAL_NARROW = 3'h5,
        MSL_PERIPHERAL = 3'h6,
        MSL_NORMAL_WIDE = 3'h7
    } msl_mode_t;

    // Low-power states
    typedef enum logic [1:0] {
        MSL_LP_RUN = 2'h0,
        MSL_LP_STOP = 2'h1,
        MSL_LP_PSEUDO = 2'h2,
        MSL_LP_WAIT = 2'h3
    } msl_lp_t;

    // Strap pins travelling together
    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_mid;
        logic mode_select_lo;
        logic flash_visibility_strap;
        logic oscillator_type_select;
    } msl_straps_t;

    // Processor requests into the sequencer
    typedef struct packed {
        logic stop_instr;
        logic wait_instruction;
        logic ext_irq;
    } msl_cpu_req_t;

    localparam logic [31:0] RESET_DATA = 32'h0000_0000;

endpackage : msl_pkg

// >>> hw/msl_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin levels
module msl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : msl_sync

// >>> hw/msl_lowpower.sv
`timescale 1ns/1ps
// Low-power sequencer: run, full stop, pseudo stop, wait
module msl_lowpower (
    input wire logic pclk,
    input wire logic presetn,
    input wire msl_pkg::msl_cpu_req_t req,
    input wire logic pseudo_sel,
    output msl_pkg::msl_lp_t state
);
    // Stop picks full or pseudo from the config bit; irq wakes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= msl_pkg::MSL_LP_RUN;
        end else begin
            case (state)
                msl_pkg::MSL_LP_RUN: begin
                    if (req.stop_instr) begin
                        state <= pseudo_sel ? msl_pkg::MSL_LP_PSEUDO
                                            : msl_pkg::MSL_LP_STOP;
                    end else if (req.wait_instruction) begin
                        state <= msl_pkg::MSL_LP_WAIT;
                    end
                end
                msl_pkg::MSL_LP_STOP, msl_pkg::MSL_LP_PSEUDO,
                msl_pkg::MSL_LP_WAIT: begin
                    if (req.ext_irq) begin
                        state <= msl_pkg::MSL_LP_RUN;
                    end
                end
                default: state <= msl_pkg::MSL_LP_RUN;
            endcase
        end
    end
endmodule : msl_lowpower

// >>> tb/msl_top_monitor.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module msl_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire msl_pkg::msl_cpu_req_t cpu_req,
    input wire logic debug_active,
    input wire logic debug_blocked,
    input wire logic osc_enable,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic lp_keep_en,
    input wire logic cpu_halt
);
    // Run state seen at the pins; low-power requests count only here
    logic run;
    assign run = core_clk_en & periph_clk_en & osc_enable & ~cpu_halt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    unmapped_err_a: assert property (pready |->
        pslverr == (paddr > 12'h010 || paddr[1:0] != 2'b00))
        else $error("slave error flag wrong");
    debug_lock_a: assert property (debug_blocked |-> !debug_active)
        else $error("debug active while blocked");
    full_stop_a: assert property (!osc_enable |->
        !core_clk_en && !periph_clk_en)
        else $error("clock running with oscillator off");
    keep_osc_a: assert property (osc_enable && !core_clk_en |->
        lp_keep_en && !periph_clk_en) else $error("pseudo stop gating wrong");
    stop_entry_a: assert property (run && cpu_req.stop_instr &&
        !cpu_req.ext_irq |-> ##2 !core_clk_en && !periph_clk_en)
        else $error("stop request not honoured");
    wait_entry_a: assert property (run && cpu_req.wait_instruction &&
        !cpu_req.stop_instr && !cpu_req.ext_irq |-> ##2
        cpu_halt && periph_clk_en && osc_enable)
        else $error("wait request not honoured");
    wait_hold_a: assert property (cpu_halt && !cpu_req.ext_irq &&
        !$past(cpu_req.ext_irq) |=> cpu_halt)
        else $error("halt dropped without wake");
    irq_wake_a: assert property (!run && cpu_req.ext_irq |->
        ##[1:3] run) else $error("no wake on interrupt");

    stop_c: cover property (run && cpu_req.stop_instr);
    wait_c: cover property (cpu_halt && periph_clk_en);
    err_c: cover property (pready && pslverr);
endmodule : msl_top_monitor

bind msl_top msl_top_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .debug_active(debug_active),
    .debug_blocked(debug_blocked), .osc_enable(osc_enable),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .lp_keep_en(lp_keep_en), .cpu_halt(cpu_halt)
);

// >>> tb/msl_pins_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Board straps, flash security bits and serial debug host
// ****************************************************************
module msl_pins_model (
    input wire logic pclk,
    input wire logic [2:0] set_mode,
    input wire logic set_fv,
    input wire logic set_osc,
    input wire logic set_sec,
    input wire logic set_erased,
    input wire logic act_go,
    output msl_pkg::msl_straps_t straps,
    output logic nv_secure,
    output logic flash_erased,
    output logic dbg_activate
);
    logic [1:0] act_cnt;

    initial begin
        act_cnt = 2'h0;
    end

    // Peripheral pattern is never strapped: bus conflicts on the board
    always @(posedge pclk) begin
        straps <= {(set_mode == 3'h6) ? 3'h7 : set_mode,
                   set_fv, set_osc};
        nv_secure <= set_sec;
        flash_erased <= set_erased;
    end

    // Activation command held three cycles so it survives the synchroniser
    always @(posedge pclk) begin
        if (act_go) begin
            act_cnt <= 2'h3;
        end else if (act_cnt != 2'h0) begin
            act_cnt <= act_cnt - 2'h1;
        end
    end
    assign dbg_activate = (act_cnt != 2'h0);
endmodule : msl_pins_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module testbench;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, dbg_activate, nv_secure, flash_erased;
    msl_pkg::msl_straps_t straps;
    msl_pkg::msl_cpu_req_t cpu_req;
    logic [8:0] pins;
    logic [2:0] set_mode;
    logic set_fv, set_osc, set_sec, set_erased, act_go, chk_pins, fe, blk;
    logic [7:0] rnd;
    logic [32:0] rq[$], rm[$];
    logic [8:0] pq[$], pm[$];
    int err_count, samples_checked, cyc;
    logic [2:0] wv[6] = '{3'h0, 3'h5, 3'h7, 3'h6, 3'h3, 3'h1};
    logic [2:0] wx[6] = '{3'h4, 3'h5, 3'h5, 3'h0, 3'h3, 3'h3};

    msl_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .straps(straps), .nv_secure(nv_secure),
        .flash_erased(flash_erased), .dbg_activate(dbg_activate),
        .cpu_req(cpu_req), .flash_mapped(pins[8]),
        .debug_active(pins[7]), .debug_blocked(pins[6]),
        .osc_colpitts(pins[5]), .osc_enable(pins[4]),
        .core_clk_en(pins[3]), .periph_clk_en(pins[2]),
        .lp_keep_en(pins[1]), .cpu_halt(pins[0]));
    msl_pins_model u_pins (.pclk(pclk), .set_mode(set_mode),
        .set_fv(set_fv), .set_osc(set_osc), .set_sec(set_sec),
        .set_erased(set_erased), .act_go(act_go), .straps(straps),
        .nv_secure(nv_secure), .flash_erased(flash_erased),
        .dbg_activate(dbg_activate));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr

    // Flash enable expected from the latched pattern and strap
    function automatic logic fe_of(input logic [2:0] m, input logic v);
        case (m)
            3'h0, 3'h4, 3'h6: return 1'b1;
            3'h2: return 1'b0;
            3'h1, 3'h3: return ~v;
            default: return v;
        endcase
    endfunction : fe_of

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Request held from setup until pready is seen at a rising edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [32:0] e,
                      input logic [32:0] m);
        rq.push_back(e);
        rm.push_back(m);
        apb(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic pexp(input logic [8:0] e, input logic [8:0] m);
        pq.push_back(e);
        pm.push_back(m);
        @(posedge pclk);
        chk_pins <= 1'b1;
        @(posedge pclk);
        chk_pins <= 1'b0;
    endtask : pexp

    task automatic boot(input logic [2:0] m, input logic s, input logic e);
        @(posedge pclk);
        presetn <= 1'b0;
        set_mode <= m;
        set_sec <= s;
        set_erased <= e;
        rnd = lfsr(rnd);
        set_fv <= rnd[0];
        set_osc <= rnd[1];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : boot

    // Pulse a processor request, then check pins and reported state
    task automatic lp(input msl_pkg::msl_cpu_req_t r, input logic [1:0] st,
                      input logic [8:0] e, input logic [8:0] m);
        @(posedge pclk);
        cpu_req <= r;
        @(posedge pclk);
        cpu_req <= '0;
        repeat (3) @(posedge pclk);
        pexp(e, m);
        rd(msl_pkg::ADDR_STATUS, {29'h0, st, 2'b00}, 33'h1_0000_000c);
    endtask : lp

    // Results are taken off the queues as they appear
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata} & rm[0], rq[0] & rm[0]);
            void'(rq.pop_front());
            void'(rm.pop_front());
        end
        if (chk_pins) begin
            check({24'h0, pins & pm[0]}, {24'h0, pq[0] & pm[0]});
            void'(pq.pop_front());
            void'(pm.pop_front());
        end
    end

    // Hang guard, far above the roughly six hundred cycles the run needs
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            wrap_up();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, act_go, chk_pins} = '0;
        {set_mode, set_fv, set_osc, set_sec, set_erased} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cpu_req = '0;
        rnd = 8'h5e;
        {err_count, samples_checked, cyc} = '0;
        repeat (3) @(posedge pclk);
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 8; m++) begin
                if (m == 6) continue;
                boot(m[2:0], s[0], 1'b0);
                fe = fe_of(m[2:0], set_fv);
                blk = s[0] && m != 0;
                pexp({fe & ~(blk && m != 4), m == 0, blk, set_osc, 5'h0},
                     9'h1e0);
                rd(msl_pkg::ADDR_MODE, 33'(m), 33'h1_0000_0007);
                rd(msl_pkg::ADDR_MISC, {31'h0, set_osc, fe},
                   {31'h4000_0001, s[0] == 1'b0});
                rd(msl_pkg::ADDR_SEC, {32'h0, s[0]}, 33'h1_0000_0001);
                if (m != 0) begin
                    @(posedge pclk);
                    act_go <= 1'b1;
                    @(posedge pclk);
                    act_go <= 1'b0;
                    repeat (8) @(posedge pclk);
                    pexp({1'b0, ~blk, 7'h0}, 9'h080);
                end
            end
        end
        boot(3'h0, 1'b1, 1'b1);
        rd(msl_pkg::ADDR_SEC, 33'h0_0000_0003, 33'h1_0000_0003);
        set_sec <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(msl_pkg::ADDR_SEC, 33'h0_0000_0002, 33'h1_0000_0003);
        for (int i = 0; i < 6; i++) begin
            if (i == 0) boot(3'h4, 1'b0, 1'b0);
            if (i == 3) boot(3'h0, 1'b0, 1'b0);
            apb(msl_pkg::ADDR_MODE, 1'b1, {29'h0, wv[i]});
            rd(msl_pkg::ADDR_MODE, {30'h0, wx[i]}, 33'h1_0000_0007);
        end
        rd(12'h014, 33'h1_0000_0000, 33'h1_0000_0000);
        boot(3'h4, 1'b0, 1'b0);
        apb(msl_pkg::ADDR_LPCTL, 1'b1, 32'h0000_0000);
        lp(3'b100, 2'h1, 9'h000, 9'h01c);
        lp(3'b001, 2'h0, 9'h01e, 9'h01f);
        apb(msl_pkg::ADDR_LPCTL, 1'b1, 32'h0000_0001);
        lp(3'b110, 2'h2, 9'h012, 9'h01e);
        lp(3'b001, 2'h0, 9'h01e, 9'h01f);
        lp(3'b010, 2'h3, 9'h015, 9'h015);
        lp(3'b100, 2'h3, 9'h015, 9'h015);
        lp(3'b001, 2'h0, 9'h01e, 9'h01f);
        repeat (4) @(posedge pclk);
        if (rq.size() != 0 || pq.size() != 0) err_count = err_count + 1;
        wrap_up();
    end
endmodule : testbench
